// ===== pcrcs_pkg.sv
package pcrcs_pkg;

  // bus identity and page geometry
  localparam logic [6:0] SLAVE_ADDR = 7'h18;
  localparam int PAGE_REGS = 128;
  localparam logic [7:0] HOME_PAGE = 8'h00;

  // register offsets, same on every page for the page select
  localparam logic [7:0] OFF_PAGE = 8'h00;
  localparam logic [7:0] OFF_SWRST = 8'h01;
  localparam logic [7:0] OFF_RSVD2 = 8'h02;
  localparam logic [7:0] OFF_THERM = 8'h03;
  localparam logic [7:0] OFF_MUX = 8'h04;
  localparam logic [7:0] OFF_PR = 8'h05;
  localparam logic [7:0] OFF_J = 8'h06;
  localparam logic [7:0] OFF_DMSB = 8'h07;
  localparam logic [7:0] OFF_DLSB = 8'h08;

  // field positions
  localparam int SWRST_BIT = 0;
  localparam int OT_BIT = 1;
  localparam int REFSEL_LSB = 2;
  localparam int CORESEL_LSB = 0;
  localparam int PLLPWR_BIT = 7;
  localparam int PDIV_LSB = 4;
  localparam int RMUL_LSB = 0;

  // reset values
  localparam logic [7:0] RST_PAGE = 8'h00;
  localparam logic RST_SWRST = 1'b0;
  localparam logic RST_THERM_D0 = 1'b0;
  localparam logic [3:0] RST_MUX = 4'h0;
  localparam logic [7:0] RST_PR = 8'h11;
  localparam logic [5:0] RST_J = 6'h04;
  localparam logic [5:0] RST_DMSB = 6'h00;
  localparam logic [7:0] RST_DLSB = 8'h00;
  localparam logic [3:0] RST_PDIV = 4'h1;
  localparam logic [4:0] RST_RMUL = 5'h01;

  // bus engine states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_REG,
    ST_WDATA,
    ST_ACK,
    ST_RDATA,
    ST_RACK,
    ST_RLOAD
  } pcrcs_state_t;

endpackage

// ===== pcrcs_sync.sv
`timescale 1ns/1ns
module pcrcs_sync
  import pcrcs_pkg::*;
#(
  parameter int W = 3
) (
  input wire logic clk, // core clock
  input wire logic rst, // synchronous reset
  input wire logic [W-1:0] pinRaw, // asynchronous pin levels
  output logic [W-1:0] pinSettled, // second stage, safe to use
  output logic [W-1:0] pinOlder // one cycle older, for edges
);

  logic [W-1:0] meta_q, meta_d;
  logic [W-1:0] sync_q, sync_d;
  logic [W-1:0] prev_q, prev_d;

  // first stage feeds only the second; edges use stages two and three
  always_comb begin
    meta_d = pinRaw;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  // idle bus level is high, so reset to ones to avoid false edges
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '1;
      sync_q <= '1;
      prev_q <= '1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  assign pinSettled = sync_q;
  assign pinOlder = prev_q;

endmodule

// ===== pcrcs_pll_decode.sv
`timescale 1ns/1ns
module pcrcs_pll_decode
  import pcrcs_pkg::*;
(
  input wire logic [7:0] prByte, // pll p/r register contents
  output logic [3:0] preDiv, // effective pre-divider 1..8
  output logic [4:0] multR // effective r multiplier 1..16
);

  logic [2:0] pCode;
  logic [3:0] rCode;

  // code zero means the largest value, so widen by one bit
  always_comb begin
    pCode = prByte[PDIV_LSB +: 3];
    rCode = prByte[RMUL_LSB +: 4];
    preDiv = (pCode == 3'h0) ? 4'h8 : {1'b0, pCode};
    multR = (rCode == 4'h0) ? 5'h10 : {1'b0, rCode};
  end

endmodule

// ===== pcrcs_regs.sv
// Overview of operation
// - control space is pages of 8-bit registers, at most 128 per page
// - after any reset page 0 is the active page
// - page changes only by writing register 0, present on every page, or by a reset
// - page select holds full 8-bit page number, resets to zero
// - writable registers read back; status registers ignore writes
// - writing one to reset bit resets control registers then self-clears
// - overtemp bit read-only, low means overheating, resets to one
// - bits 3:2 of clock mux pick the pll reference source
// - bits 1:0 of clock mux pick the core clock source
// - pll p/r bit 7 powers the pll, resets to zero
// - pre-divider divides by code, code zero divides by eight
// - r multiplier multiplies by code, code zero means sixteen
// - j multiplier 1..63 resets to 4; host avoids code zero
// - fraction msb takes effect only when lsb write follows it
// - all register access goes over the two-wire control bus
// - fraction lsb register at 0x08 holds fraction bits 7:0
// - writes without stop auto-increment the register address
// - device is a slave only, answering address 0011 000
`timescale 1ns/1ns
module pcrcs_regs
  import pcrcs_pkg::*;
(
  input wire logic clk, // core clock, 250 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic scl, // bus clock pin
  input wire logic sdaIn, // bus data pin level
  output logic sdaOut, // bus data drive value, always low
  output logic sdaOe, // high while pulling data low
  input wire logic overtempN, // amplifier overtemp pin, low is hot
  output logic [1:0] pllRefSelect, // pll reference source
  output logic [1:0] coreClockSelect, // core clock source
  output logic pllPowerUp, // pll power enable
  output logic [3:0] pllPreDiv, // decoded pre-divider
  output logic [4:0] pllMultR, // decoded r multiplier
  output logic [5:0] pllMultJ, // j multiplier
  output logic [13:0] pllFraction // applied fractional multiplier
);

  // synchronised pins
  logic [2:0] pinSync, pinPrev;
  logic sclS, sdaS, otS, sclP, sdaP;
  logic sclRise, sclFall, startCond, stopCond;

  pcrcs_sync #(.W(3)) u_pcrcs_sync (
    .clk(clk),
    .rst(rst),
    .pinRaw({overtempN, sdaIn, scl}),
    .pinSettled(pinSync),
    .pinOlder(pinPrev)
  );

  // bus conditions from the settled copies
  assign sclS = pinSync[0];
  assign sdaS = pinSync[1];
  assign otS = pinSync[2];
  assign sclP = pinPrev[0];
  assign sdaP = pinPrev[1];
  assign sclRise = sclS & ~sclP;
  assign sclFall = ~sclS & sclP;
  assign startCond = sclS & sclP & sdaP & ~sdaS;
  assign stopCond = sclS & sclP & ~sdaP & sdaS;

  // engine state
  pcrcs_state_t st_q, st_d, ackNext_q, ackNext_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] ptr_q, ptr_d;
  logic ackOn_q, ackOn_d;
  logic oe_q, oe_d;
  logic sdaOut_q;
  logic [7:0] rxByte;
  logic wrEn;
  logic [7:0] rdData;

  // register bank state
  logic [7:0] page_q, page_d;
  logic swRst_q, swRst_d;
  logic thD0_q, thD0_d;
  logic [3:0] mux_q, mux_d;
  logic [7:0] pr_q, pr_d;
  logic [5:0] j_q, j_d;
  logic [5:0] dmsb_q, dmsb_d;
  logic [5:0] fracHi_q, fracHi_d;
  logic [7:0] dlsb_q, dlsb_d;
  logic msbPend_q, msbPend_d;
  logic [3:0] pDiv_q, pDiv_d;
  logic [4:0] rMul_q, rMul_d;
  logic [3:0] decP;
  logic [4:0] decR;
  logic inPage;

  pcrcs_pll_decode u_pcrcs_pll_decode (
    .prByte(pr_q),
    .preDiv(decP),
    .multR(decR)
  );

  // offsets at 128 and above are outside any page
  assign inPage = (ptr_q < 8'(PAGE_REGS));

  // read mux; page select answers on every page, others on page 0 only
  always_comb begin
    rdData = 8'h00;
    if (!inPage) begin
      rdData = 8'h00;
    end else if (ptr_q == OFF_PAGE) begin
      rdData = page_q;
    end else if (page_q == HOME_PAGE) begin
      case (ptr_q)
        OFF_SWRST: rdData = {7'h00, swRst_q};
        OFF_THERM: rdData = {6'h00, otS, thD0_q};
        OFF_MUX: rdData = {4'h0, mux_q};
        OFF_PR: rdData = pr_q;
        OFF_J: rdData = {2'h0, j_q};
        OFF_DMSB: rdData = {2'h0, dmsb_q};
        OFF_DLSB: rdData = dlsb_q;
        default: rdData = 8'h00;
      endcase
    end
  end

  // bus engine next state; start and stop win over any bit activity
  always_comb begin
    st_d = st_q;
    ackNext_d = ackNext_q;
    bit_d = bit_q;
    shift_d = shift_q;
    ptr_d = ptr_q;
    ackOn_d = ackOn_q;
    oe_d = oe_q;
    wrEn = 1'b0;
    rxByte = {shift_q[6:0], sdaS};
    if (startCond) begin
      st_d = ST_ADDR;
      bit_d = 3'h0;
      oe_d = 1'b0;
      ackOn_d = 1'b0;
    end else if (stopCond) begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
      ackOn_d = 1'b0;
    end else begin
      case (st_q)
        ST_ADDR, ST_REG, ST_WDATA: begin
          if (sclRise) begin
            shift_d = rxByte;
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              st_d = ST_ACK;
              ackOn_d = 1'b0;
              if (st_q == ST_ADDR) begin
                if (rxByte[7:1] != SLAVE_ADDR) begin
                  st_d = ST_IDLE;
                end
                ackNext_d = rxByte[0] ? ST_RDATA : ST_REG;
              end else if (st_q == ST_REG) begin
                ptr_d = rxByte;
                ackNext_d = ST_WDATA;
              end else begin
                wrEn = 1'b1;
                ptr_d = ptr_q + 8'h01;
                ackNext_d = ST_WDATA;
              end
            end
          end
        end
        ST_ACK: begin
          // pull low for one bus clock, then hand the line back, or drive the first bit on a read
          if (sclFall) begin
            if (!ackOn_q) begin
              oe_d = 1'b1;
              ackOn_d = 1'b1;
            end else begin
              ackOn_d = 1'b0;
              oe_d = 1'b0;
              bit_d = 3'h0;
              st_d = ackNext_q;
              if (ackNext_q == ST_RDATA) begin
                shift_d = rdData;
                oe_d = ~rdData[7];
              end
            end
          end
        end
        ST_RDATA: begin
          if (sclRise) begin
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              st_d = ST_RACK;
            end
          end else if (sclFall) begin
            shift_d = {shift_q[6:0], 1'b0};
            oe_d = ~shift_q[6];
          end
        end
        ST_RACK: begin
          // master answers; an ack asks for the next register
          if (sclFall) begin
            oe_d = 1'b0;
          end else if (sclRise) begin
            if (!sdaS) begin
              ptr_d = ptr_q + 8'h01;
              st_d = ST_RLOAD;
            end else begin
              st_d = ST_IDLE;
            end
          end
        end
        ST_RLOAD: begin
          if (sclFall) begin
            shift_d = rdData;
            oe_d = ~rdData[7];
            bit_d = 3'h0;
            st_d = ST_RDATA;
          end
        end
        default: begin
          st_d = ST_IDLE;
        end
      endcase
    end
  end

  // engine registers; a software reset leaves a live transfer alone
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= ST_IDLE;
      ackNext_q <= ST_IDLE;
      bit_q <= 3'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      ackOn_q <= 1'b0;
      oe_q <= 1'b0;
      sdaOut_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ackNext_q <= ackNext_d;
      bit_q <= bit_d;
      shift_q <= shift_d;
      ptr_q <= ptr_d;
      ackOn_q <= ackOn_d;
      oe_q <= oe_d;
      sdaOut_q <= 1'b0; // open drain: only ever pulls low
    end
  end

  // register bank next values; only bus writes reach it
  always_comb begin
    page_d = page_q;
    swRst_d = swRst_q;
    thD0_d = thD0_q;
    mux_d = mux_q;
    pr_d = pr_q;
    j_d = j_q;
    dmsb_d = dmsb_q;
    fracHi_d = fracHi_q;
    dlsb_d = dlsb_q;
    msbPend_d = msbPend_q;
    pDiv_d = decP;
    rMul_d = decR;
    if (swRst_q) begin
      page_d = RST_PAGE;
      swRst_d = RST_SWRST;
      thD0_d = RST_THERM_D0;
      mux_d = RST_MUX;
      pr_d = RST_PR;
      j_d = RST_J;
      dmsb_d = RST_DMSB;
      fracHi_d = RST_DMSB;
      dlsb_d = RST_DLSB;
      msbPend_d = 1'b0;
      pDiv_d = RST_PDIV;
      rMul_d = RST_RMUL;
    end else if (wrEn && inPage) begin
      msbPend_d = 1'b0; // any other in-page write breaks the pair
      if (ptr_q == OFF_PAGE) begin
        page_d = rxByte;
      end else if (page_q == HOME_PAGE) begin
        case (ptr_q)
          OFF_SWRST: swRst_d = rxByte[SWRST_BIT];
          OFF_THERM: thD0_d = rxByte[0];
          OFF_MUX: mux_d = rxByte[3:0];
          OFF_PR: pr_d = rxByte;
          OFF_J: j_d = rxByte[5:0];
          OFF_DMSB: begin
            dmsb_d = rxByte[5:0];
            msbPend_d = 1'b1;
          end
          OFF_DLSB: begin
            dlsb_d = rxByte;
            if (msbPend_q) begin
              fracHi_d = dmsb_q;
            end
          end
          default: msbPend_d = 1'b0;
        endcase
      end
    end
  end

  // bank registers
  always_ff @(posedge clk) begin
    if (rst) begin
      page_q <= RST_PAGE;
      swRst_q <= RST_SWRST;
      thD0_q <= RST_THERM_D0;
      mux_q <= RST_MUX;
      pr_q <= RST_PR;
      j_q <= RST_J;
      dmsb_q <= RST_DMSB;
      fracHi_q <= RST_DMSB;
      dlsb_q <= RST_DLSB;
      msbPend_q <= 1'b0;
      pDiv_q <= RST_PDIV;
      rMul_q <= RST_RMUL;
    end else begin
      page_q <= page_d;
      swRst_q <= swRst_d;
      thD0_q <= thD0_d;
      mux_q <= mux_d;
      pr_q <= pr_d;
      j_q <= j_d;
      dmsb_q <= dmsb_d;
      fracHi_q <= fracHi_d;
      dlsb_q <= dlsb_d;
      msbPend_q <= msbPend_d;
      pDiv_q <= pDiv_d;
      rMul_q <= rMul_d;
    end
  end

  // outputs straight from flops; decoded values lag the field by a cycle
  assign sdaOut = sdaOut_q;
  assign sdaOe = oe_q;
  assign pllRefSelect = mux_q[REFSEL_LSB +: 2];
  assign coreClockSelect = mux_q[CORESEL_LSB +: 2];
  assign pllPowerUp = pr_q[PLLPWR_BIT];
  assign pllPreDiv = pDiv_q;
  assign pllMultR = rMul_q;
  assign pllMultJ = j_q;
  assign pllFraction = {fracHi_q, dlsb_q};

endmodule

// ===== pcrcs_regs_monitor.sv
`timescale 1ns/1ns
module pcrcs_regs_monitor
  import pcrcs_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic scl, // bus clock
  input wire logic sdaIn, // bus data
  input wire logic sdaOut, // drive value
  input wire logic sdaOe, // drive enable
  input wire logic overtempN, // hot pin
  input wire logic [1:0] pllRefSelect, // ref mux
  input wire logic [1:0] coreClockSelect, // core mux
  input wire logic pllPowerUp, // power
  input wire logic [3:0] pllPreDiv, // p
  input wire logic [4:0] pllMultR, // r
  input wire logic [5:0] pllMultJ, // j
  input wire logic [13:0] pllFraction // d
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // open drain: the pin is only ever pulled low
  property p_drive_low; sdaOut == 1'b0; endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("data drive value not low");
  // data line moves only while the bus clock is low
  property p_oe_scl_low; $changed(sdaOe) |-> !scl; endproperty
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("data drive moved with clock high");
  // a driven bit stands at least eight clocks
  property p_oe_hold; $rose(sdaOe) |-> sdaOe [*8]; endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("driven bit too short");
  // settings change only after a byte clocked in, clock still high
  property p_cfg_scl_high;
    $changed({pllRefSelect, coreClockSelect, pllPowerUp, pllPreDiv,
      pllMultR, pllMultJ, pllFraction}) |-> scl;
  endproperty
  a_cfg_scl_high: assert property (p_cfg_scl_high)
    else $error("setting changed outside a bus write");
  property p_prediv_range; pllPreDiv inside {[4'h1:4'h8]}; endproperty
  a_prediv_range: assert property (p_prediv_range)
    else $error("pre-divider out of range");
  property p_multr_range; pllMultR inside {[5'h01:5'h10]}; endproperty
  a_multr_range: assert property (p_multr_range)
    else $error("r multiplier out of range");
  // reset values seen at the first edge after release
  property p_rst_pll;
    $fell(rst) |-> !pllPowerUp && pllPreDiv == RST_PDIV
      && pllMultR == RST_RMUL;
  endproperty
  a_rst_pll: assert property (p_rst_pll)
    else $error("pll reset values wrong");
  property p_rst_j;
    $fell(rst) |-> pllMultJ == RST_J && pllFraction == 14'h0000;
  endproperty
  a_rst_j: assert property (p_rst_j)
    else $error("multiplier reset values wrong");
  property p_rst_mux;
    $fell(rst) |-> pllRefSelect == 2'h0 && coreClockSelect == 2'h0
      && !sdaOe;
  endproperty
  a_rst_mux: assert property (p_rst_mux)
    else $error("mux reset values wrong");
endmodule
bind pcrcs_regs pcrcs_regs_monitor u_pcrcs_regs_monitor (.clk(clk),
  .rst(rst), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .overtempN(overtempN), .pllRefSelect(pllRefSelect),
  .coreClockSelect(coreClockSelect), .pllPowerUp(pllPowerUp),
  .pllPreDiv(pllPreDiv), .pllMultR(pllMultR), .pllMultJ(pllMultJ),
  .pllFraction(pllFraction));

// ===== pcrcs_host.sv
`timescale 1ns/1ns
module pcrcs_host
  import pcrcs_pkg::*;
(
  input wire logic clk, // pacing clock
  input wire logic sda, // resolved wire
  output logic scl, // bus clock
  output logic sdaLow // pulls data low
);
  localparam int H = 10; // half bit, far above the 4 clk minimum
  logic [7:0] rdq [9]; // bytes of the last read
  int nacks; // bytes nobody acknowledged
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
    nacks = 0;
  end
  task automatic hclk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // data set with clock low, sampled at end of high phase
  task automatic bitIo(input logic v, output logic r);
    sdaLow = ~v;
    hclk(H);
    scl = 1'b1;
    hclk(H);
    r = sda;
    scl = 1'b0;
    hclk(4);
  endtask
  // start also serves as repeated start: data rises before clock
  task automatic start;
    sdaLow = 1'b0;
    hclk(4);
    scl = 1'b1;
    hclk(H);
    sdaLow = 1'b1;
    hclk(H);
    scl = 1'b0;
    hclk(4);
  endtask
  task automatic stop;
    sdaLow = 1'b1;
    hclk(4);
    scl = 1'b1;
    hclk(H);
    sdaLow = 1'b0;
    hclk(H);
  endtask
  task automatic sendB(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bitIo(b[i], r);
    bitIo(1'b1, r);
    if (r) nacks++;
  endtask
  // every access goes over the two-wire bus
  task automatic probe(input logic [7:0] a);
    start();
    sendB(a);
    stop();
  endtask
  // msb then lsb land back to back in one auto-increment burst
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input int n);
    start();
    sendB({SLAVE_ADDR, 1'b0});
    sendB(a);
    for (int k = n - 1; k >= 0; k--) sendB(d[8*k +: 8]);
    stop();
  endtask
  // acknowledge every byte but the last
  task automatic rd(input logic [7:0] a, input int n);
    logic r;
    start();
    sendB({SLAVE_ADDR, 1'b0});
    sendB(a);
    start();
    sendB({SLAVE_ADDR, 1'b1});
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        bitIo(1'b1, r);
        rdq[k][i] = r;
      end
      bitIo(k == n - 1, r);
    end
    stop();
  endtask
endmodule

// ===== test_pcrcs_regs.sv
`timescale 1ns/1ns
module test_pcrcs_regs
  import pcrcs_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic overtempN = 1'b1;
  logic scl, sdaLow, sdaOut, sdaOe, sda, pllPowerUp;
  logic [1:0] pllRefSelect, coreClockSelect;
  logic [3:0] pllPreDiv;
  logic [4:0] pllMultR;
  logic [5:0] pllMultJ;
  logic [13:0] pllFraction;
  logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h11, 8'h04,
    8'h00, 8'h00};
  int n_fail = 0;
  int checks_done = 0;
  // pull-up wire: low when either party pulls
  assign sda = ~(sdaOe | sdaLow);
  always #2 clk = ~clk;
  pcrcs_regs u_pcrcs_regs (.clk(clk), .rst(rst), .scl(scl), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .overtempN(overtempN),
    .pllRefSelect(pllRefSelect), .coreClockSelect(coreClockSelect),
    .pllPowerUp(pllPowerUp), .pllPreDiv(pllPreDiv), .pllMultR(pllMultR),
    .pllMultJ(pllMultJ), .pllFraction(pllFraction));
  pcrcs_host u_pcrcs_host (.clk(clk), .sda(sda), .scl(scl), .sdaLow(sdaLow));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    if (n_fail == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic rd1(input logic [7:0] a, input logic [7:0] e);
    u_pcrcs_host.rd(a, 1);
    chk(u_pcrcs_host.rdq[0], e);
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    finish_test();
  end
  initial begin
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    u_pcrcs_host.hclk(4);
    // reset image; register 2 is reserved, so two bursts step around it
    u_pcrcs_host.rd(OFF_PAGE, 2);
    for (int i = 0; i < 2; i++) chk(u_pcrcs_host.rdq[i], rv[i]);
    u_pcrcs_host.rd(OFF_THERM, 6);
    for (int i = 0; i < 6; i++) chk(u_pcrcs_host.rdq[i], rv[i + 3]);
    // every code of both clock muxes
    for (int c = 0; c < 4; c++) begin
      u_pcrcs_host.wr(OFF_MUX, 16'(3 * c + 3), 1);
      chk({pllRefSelect, coreClockSelect}, 16'(3 * c + 3));
    end
    // code zero of p and r means eight and sixteen; j by increment
    u_pcrcs_host.wr(OFF_PR, 16'h803F, 2);
    chk({pllPowerUp, pllPreDiv, pllMultR, pllMultJ}, 16'hC43F);
    u_pcrcs_host.wr(OFF_PR, 16'h007F, 1);
    chk({pllPowerUp, pllPreDiv, pllMultR, pllMultJ}, 16'h3BFF);
    // fraction pair, then a broken pair leaves the old high part
    u_pcrcs_host.wr(OFF_DMSB, 16'h2A5C, 2);
    chk(pllFraction, 16'h2A5C);
    u_pcrcs_host.wr(OFF_DMSB, 16'h0015, 1);
    u_pcrcs_host.wr(OFF_J, 16'h0004, 1);
    u_pcrcs_host.wr(OFF_DLSB, 16'h0033, 1);
    chk(pllFraction, 16'h2A33);
    rd1(OFF_DMSB, 8'h15);
    // status bit ignores writes and follows the pin; host writes reset value
    overtempN = 1'b0;
    u_pcrcs_host.wr(OFF_THERM, 16'h0002, 1);
    rd1(OFF_THERM, 8'h00);
    overtempN = 1'b1;
    rd1(OFF_THERM, 8'h02);
    u_pcrcs_host.wr(8'h80, 16'h005A, 1);
    rd1(8'h80, 8'h00);
    u_pcrcs_host.wr(OFF_PAGE, 16'h000D, 1);
    rd1(OFF_PAGE, 8'h0D);
    // on another page only register 0 is live
    u_pcrcs_host.wr(OFF_PAGE, 16'h0001, 1);
    u_pcrcs_host.wr(OFF_MUX, 16'h0005, 1);
    chk({pllRefSelect, coreClockSelect}, 16'h000C);
    rd1(OFF_MUX, 8'h00);
    u_pcrcs_host.wr(OFF_PAGE, 16'h0000, 1);
    rd1(OFF_MUX, 8'h0C);
    // zero to the reset bit does nothing, one resets the bank
    u_pcrcs_host.wr(OFF_SWRST, 16'h0000, 1);
    chk({pllPreDiv, pllMultR}, 16'h00EF);
    u_pcrcs_host.wr(OFF_SWRST, 16'h0001, 1);
    chk({pllRefSelect, coreClockSelect, pllPreDiv, pllMultR}, 16'h0021);
    chk(pllFraction, 16'h0000);
    u_pcrcs_host.rd(OFF_PAGE, 2);
    chk({u_pcrcs_host.rdq[0], u_pcrcs_host.rdq[1]}, 16'h0000);
    chk(16'(u_pcrcs_host.nacks), 16'h0000);
    u_pcrcs_host.probe({SLAVE_ADDR ^ 7'h01, 1'b0});
    chk(16'(u_pcrcs_host.nacks), 16'h0001);
    finish_test();
  end
endmodule
